/* File: design/dbgent_core.sv */
// debug entry controller: pc advance per entry cause and exception priority
`timescale 1ns/1ps
module dbgent_core (
    // clock and reset
    input  wire logic                       sys_clk_i,
    input  wire logic                       rst_b_i,
    // core pipeline events and debug request
    input  wire dbgent_pkg::dbgent_core_evt_t core_evt_i,
    input  wire logic                       debug_request_in_i,
    // scan side commands while halted
    input  wire dbgent_pkg::dbgent_dbg_cmd_t dbg_cmd_i,
    // debug status
    output logic                            debug_ack_o,
    output logic                            sys_run_o,
    output dbgent_pkg::dbgent_cause_t       cause_o,
    output dbgent_pkg::dbgent_mode_t        mode_o,
    output logic                            irq_mask_o,
    // exception bookkeeping
    output logic                            take_pf_abort_o,
    output logic                            abort_seen_o,
    output logic                            irq_seen_o,
    // program counter advance
    output logic                            pc_adv_valid_o,
    output logic [2:0]                      pc_adv_o,
    output logic [dbgent_pkg::PC_TOT_W-1:0] pc_total_o
);
    import dbgent_pkg::*;

    typedef enum logic [2:0] {
        ST_RUN,
        ST_WAIT_VEC,
        ST_HALT,
        ST_SYS,
        ST_SYS_ABT
    } dbgent_state_t;

    dbgent_state_t state;
    dbgent_state_t next_state;
    logic          rst_meta;
    logic          rst_sync_b;
    logic          req_pend;
    logic          irq_any;
    logic          wpt_exc;
    logic          boundary;
    logic          fetch_ok;
    logic          take_bkpt;
    logic          take_wpt;
    logic          take_req;
    logic          enter_now;
    logic          next_adv_valid;
    logic [2:0]    next_adv;
    dbgent_cause_t next_cause;

    // two-stage reset release; assertion stays asynchronous
    always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta   <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta   <= 1'b1;
            rst_sync_b <= rst_meta;
        end
    end

    // instruction boundary decode while running
    assign boundary  = (state == ST_RUN) && core_evt_i.instr_done;
    assign irq_any   = core_evt_i.irq || core_evt_i.fiq;
    assign wpt_exc   = core_evt_i.d_abort || irq_any;
    // a prefetch abort at the boundary blocks every entry; the abort runs
    // first and a pending request waits for a later boundary
    assign fetch_ok  = boundary && !core_evt_i.pf_abort;
    // prefetch abort masks the breakpoint completely
    assign take_bkpt = fetch_ok && core_evt_i.bkpt;
    assign take_wpt  = fetch_ok && core_evt_i.wpt && !core_evt_i.bkpt;
    // request waits for the running instruction to complete
    assign take_req  = fetch_ok && (req_pend || debug_request_in_i)
                       && !core_evt_i.bkpt && !core_evt_i.wpt;
    assign enter_now = take_bkpt || (take_wpt && !wpt_exc) || take_req;

    // a request raised while halted is dropped; the core is already in debug
    // debug request is sticky until taken; a new request in the taking cycle is
    // the same request, so nothing is lost by clearing here
    always_ff @(posedge sys_clk_i or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            req_pend <= 1'b0;
        end else if (take_req) begin
            req_pend <= 1'b0;
        end else if (debug_request_in_i && state == ST_RUN) begin
            req_pend <= 1'b1;
        end
    end

    // next state and pc advance for this cycle
    always_comb begin
        next_state     = state;
        next_adv_valid = 1'b0;
        next_adv       = PC_ADV_RST;
        next_cause     = cause_o;
        unique case (state)
            ST_RUN: begin
                if (take_bkpt) begin
                    next_state     = ST_HALT;
                    next_adv_valid = 1'b1;
                    next_adv       = PC_ADV_BKPT;
                    next_cause     = DBGENT_CAUSE_BKPT;
                end else if (take_wpt && wpt_exc) begin
                    // hold entry until the exception vector is fetched
                    next_state = ST_WAIT_VEC;
                    next_cause = DBGENT_CAUSE_WPT_EXC;
                end else if (take_wpt) begin
                    next_state     = ST_HALT;
                    next_adv_valid = 1'b1;
                    next_adv       = PC_ADV_WPT;
                    next_cause     = DBGENT_CAUSE_WPT;
                end else if (take_req) begin
                    next_state     = ST_HALT;
                    next_adv_valid = 1'b1;
                    next_adv       = PC_ADV_REQ;
                    next_cause     = DBGENT_CAUSE_REQ;
                end
            end
            ST_WAIT_VEC: begin
                // cause was set on the way in and is kept for the debugger
                if (core_evt_i.vec_fetched) begin
                    next_state     = ST_HALT;
                    next_adv_valid = 1'b1;
                    next_adv       = PC_ADV_WPT_EXC;
                end
            end
            ST_HALT: begin
                // resume outranks a system access so exit is never delayed
                if (dbg_cmd_i.resume) begin
                    next_state = ST_RUN;
                end else if (dbg_cmd_i.sys_go) begin
                    next_state     = ST_SYS;
                    next_adv_valid = 1'b1;
                    next_adv       = PC_ADV_SYS;
                end else if (dbg_cmd_i.step) begin
                    next_adv_valid = 1'b1;
                    next_adv       = PC_ADV_STEP;
                end
            end
            ST_SYS: begin
                // abort takes precedence over completion in the same cycle
                if (dbg_cmd_i.sys_abort) begin
                    next_state = ST_SYS_ABT;
                end else if (dbg_cmd_i.sys_done) begin
                    next_state = ST_HALT;
                    next_cause = DBGENT_CAUSE_SYS;
                end
            end
            ST_SYS_ABT: begin
                // one cycle in abort mode before halting again
                next_state = ST_HALT;
                next_cause = DBGENT_CAUSE_SYS;
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    // the vector wait is left only on the core's vector fetch; a core that
    // never fetches the vector keeps the block out of debug
    // state register
    always_ff @(posedge sys_clk_i or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            state <= ST_RUN;
        end else begin
            state <= next_state;
        end
    end

    // cause of entry, held for the debugger to read
    // a system access overwrites it, so the entry cause is only valid
    // until the first system-speed access returns
    always_ff @(posedge sys_clk_i or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            cause_o <= DBGENT_CAUSE_NONE;
        end else begin
            cause_o <= next_cause;
        end
    end

    // acknowledge is high while halted; drops during system-speed access
    // it follows next_state, so it changes at the same edge as the state
    always_ff @(posedge sys_clk_i or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            debug_ack_o <= 1'b0;
            sys_run_o   <= 1'b0;
        end else begin
            debug_ack_o <= (next_state == ST_HALT);
            sys_run_o   <= (next_state == ST_SYS);
        end
    end

    // pc advance pulse and running total since entry (4 or 3, + N, + 3S)
    // the total restarts at every entry; the vector wait loads zero first
    // and adds its three when the vector has been fetched
    always_ff @(posedge sys_clk_i or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            pc_adv_valid_o <= 1'b0;
            pc_adv_o       <= PC_ADV_RST;
            pc_total_o     <= PC_TOT_RST;
        end else begin
            pc_adv_valid_o <= next_adv_valid;
            pc_adv_o       <= next_adv;
            if (state == ST_RUN && next_state != ST_RUN) begin
                pc_total_o <= {{(PC_TOT_W-3){1'b0}}, next_adv};
            end else if (next_adv_valid) begin
                // total wraps; long sessions must be tracked by the debugger
                pc_total_o <= pc_total_o + {{(PC_TOT_W-3){1'b0}}, next_adv};
            end
        end
    end

    // processor mode follows exceptions taken around debug entry
    always_ff @(posedge sys_clk_i or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            mode_o <= DBGENT_MODE_USER;
        end else if (boundary && core_evt_i.pf_abort) begin
            mode_o <= DBGENT_MODE_ABT;
        end else if (take_wpt && core_evt_i.d_abort) begin
            mode_o <= DBGENT_MODE_ABT;
        end else if ((take_wpt && wpt_exc) || enter_now) begin
            // pending interrupt steers the entry mode, fast first
            if (core_evt_i.fiq) begin
                mode_o <= DBGENT_MODE_FIQ;
            end else if (core_evt_i.irq) begin
                mode_o <= DBGENT_MODE_IRQ;
            end
        end else if (state == ST_SYS && dbg_cmd_i.sys_abort) begin
            mode_o <= DBGENT_MODE_ABT;
        end
    end

    // prefetch abort request to the exception logic, one cycle
    // the same boundary that raises this pulse also blocks every entry
    always_ff @(posedge sys_clk_i or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            take_pf_abort_o <= 1'b0;
        end else begin
            take_pf_abort_o <= boundary && core_evt_i.pf_abort;
        end
    end

    // interrupts masked from entry until resume, so halting never vectors
    // the mask covers the vector wait too, so a later interrupt cannot
    // steer the entry mode once it has been chosen
    always_ff @(posedge sys_clk_i or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            irq_mask_o <= 1'b0;
        end else if (state == ST_RUN && next_state != ST_RUN) begin
            irq_mask_o <= 1'b1;
        end else if (state == ST_HALT && dbg_cmd_i.resume) begin
            irq_mask_o <= 1'b0;
        end
    end

    // remembered exceptions; cleared on resume, a new event in that cycle wins
    // only resume clears them, so the debugger may read them at any point
    always_ff @(posedge sys_clk_i or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            abort_seen_o <= 1'b0;
            irq_seen_o   <= 1'b0;
        end else begin
            if ((take_wpt && core_evt_i.d_abort)
                || (state == ST_SYS && dbg_cmd_i.sys_abort)) begin
                abort_seen_o <= 1'b1;
            end else if (state == ST_HALT && dbg_cmd_i.resume) begin
                abort_seen_o <= 1'b0;
            end
            if ((enter_now || take_wpt) && irq_any) begin
                irq_seen_o <= 1'b1;
            end else if (state == ST_HALT && dbg_cmd_i.resume) begin
                irq_seen_o <= 1'b0;
            end
        end
    end
endmodule

/* File: dv/dbgent_core_chk.sv */
// checker for entry advances, exception priority and halt commands
`timescale 1ns/1ps
module dbgent_core_chk (
    // clock and reset
    input wire logic                        sys_clk_i,
    input wire logic                        rst_b_i,
    // inputs
    input wire dbgent_pkg::dbgent_core_evt_t core_evt_i,
    input wire logic                        debug_request_in_i,
    input wire dbgent_pkg::dbgent_dbg_cmd_t  dbg_cmd_i,
    // outputs
    input wire logic                        debug_ack_o,
    input wire logic                        sys_run_o,
    input wire dbgent_pkg::dbgent_cause_t   cause_o,
    input wire dbgent_pkg::dbgent_mode_t    mode_o,
    input wire logic                        irq_mask_o,
    input wire logic                        take_pf_abort_o,
    input wire logic                        abort_seen_o,
    input wire logic                        irq_seen_o,
    input wire logic                        pc_adv_valid_o,
    input wire logic [2:0]                  pc_adv_o,
    input wire logic [dbgent_pkg::PC_TOT_W-1:0] pc_total_o
);
    import dbgent_pkg::*;
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_b_i);
    // running is inferred from outputs; the mask is high in every other state
    wire logic run = !debug_ack_o && !sys_run_o && !irq_mask_o;
    wire logic done_ok = run && core_evt_i.instr_done && !core_evt_i.pf_abort;
    wire logic bare_wpt = done_ok && !core_evt_i.bkpt && core_evt_i.wpt;
    wire logic exc = core_evt_i.d_abort || core_evt_i.irq || core_evt_i.fiq;
    bkpt_entry_a: assert property (done_ok && core_evt_i.bkpt |=> debug_ack_o
        && pc_adv_valid_o && pc_adv_o == 3'h4 && cause_o == DBGENT_CAUSE_BKPT && irq_mask_o)
        else $error("breakpoint entry wrong");
    pf_abort_wins_a: assert property (run && core_evt_i.instr_done && core_evt_i.pf_abort
        |=> take_pf_abort_o && !debug_ack_o && mode_o == DBGENT_MODE_ABT)
        else $error("prefetch abort not taken");
    wpt_entry_a: assert property (bare_wpt && !exc
        |=> pc_adv_o == 3'h4 && cause_o == DBGENT_CAUSE_WPT)
        else $error("watchpoint entry wrong");
    wpt_abort_wait_a: assert property (bare_wpt && core_evt_i.d_abort
        |=> !debug_ack_o && mode_o == DBGENT_MODE_ABT && abort_seen_o)
        else $error("watchpoint abort not held off");
    wpt_exc_adv_a: assert property ($rose(debug_ack_o) && cause_o == DBGENT_CAUSE_WPT_EXC
        |-> pc_adv_valid_o && pc_adv_o == 3'h3 && $past(core_evt_i.vec_fetched))
        else $error("watchpoint exception entry wrong");
    irq_entry_mode_a: assert property (done_ok && core_evt_i.bkpt && core_evt_i.irq
        && !core_evt_i.fiq |=> mode_o == DBGENT_MODE_IRQ && irq_seen_o)
        else $error("interrupt mode not kept");
    req_entry_a: assert property (done_ok && $past(run) && !core_evt_i.bkpt && !core_evt_i.wpt
        && debug_request_in_i && $past(debug_request_in_i)
        |=> cause_o == DBGENT_CAUSE_REQ && pc_adv_o == 3'h3)
        else $error("request entry wrong");
    step_adv_a: assert property (debug_ack_o && dbg_cmd_i.step && !dbg_cmd_i.resume
        && !dbg_cmd_i.sys_go |=> pc_adv_o == 3'h1 && pc_total_o == $past(pc_total_o) + 8'h01)
        else $error("step advance wrong");
    sys_adv_a: assert property (debug_ack_o && dbg_cmd_i.sys_go && !dbg_cmd_i.resume
        |=> sys_run_o && !debug_ack_o && pc_adv_o == 3'h3)
        else $error("system access advance wrong");
    sys_done_a: assert property (sys_run_o && dbg_cmd_i.sys_done && !dbg_cmd_i.sys_abort
        |=> debug_ack_o && cause_o == DBGENT_CAUSE_SYS && !pc_adv_valid_o)
        else $error("system access return wrong");
    sys_abort_a: assert property (sys_run_o && dbg_cmd_i.sys_abort
        |=> mode_o == DBGENT_MODE_ABT ##1 debug_ack_o)
        else $error("system abort order wrong");
    resume_exit_a: assert property (debug_ack_o && dbg_cmd_i.resume
        |=> !debug_ack_o && !irq_mask_o && !irq_seen_o)
        else $error("resume did not exit");
endmodule
bind dbgent_core dbgent_core_chk u_dbgent_core_chk (.sys_clk_i, .rst_b_i, .core_evt_i,
    .debug_request_in_i, .dbg_cmd_i, .debug_ack_o, .sys_run_o, .cause_o, .mode_o, .irq_mask_o,
    .take_pf_abort_o, .abort_seen_o, .irq_seen_o, .pc_adv_valid_o, .pc_adv_o, .pc_total_o);

/* File: dv/dbgent_dbg_model.sv */
// debugger model: halted command sequences and the return offset
`timescale 1ns/1ps
module dbgent_dbg_model (
    // clock
    input  wire logic                   sys_clk_i,
    // core status
    input  wire logic                   debug_ack_i,
    input  wire logic                   sys_run_i,
    // scan side commands
    output dbgent_pkg::dbgent_dbg_cmd_t cmd_o
);
    import dbgent_pkg::*;
    initial cmd_o = '0;
    // one-cycle command after gap + 1 idle cycles, raised just after an edge
    task automatic pulse(input logic [4:0] c, input int gap);
        repeat (gap) @(posedge sys_clk_i);
        @(posedge sys_clk_i);
        #1 cmd_o = c;
        @(posedge sys_clk_i);
        #1 cmd_o = '0;
    endtask
    // n debug-speed instructions, the last being the branch, and s system accesses
    task automatic session(input int entry, n, s, bit abt, int gap, output int ofs);
        repeat (n - 1) pulse(5'h10, gap);
        for (int i = 0; i < s; i++) begin
            pulse(5'h08, gap);
            pulse((abt && i == 0) ? 5'h02 : 5'h04, gap);
            // an aborted access spends a cycle in abort mode first
            for (int k = 0; k < 8 && !debug_ack_i; k++) #40;
        end
        pulse(5'h10, gap);
        ofs = entry + n + 3 * s;
    endtask
endmodule

/* File: dv/testbench.sv */
// testbench: random debug sessions around directed entry corners
`timescale 1ns/1ps
module testbench;
    import dbgent_pkg::*;
    logic                sys_clk_i = 1'b0;
    logic                rst_b_i = 1'b0;
    dbgent_core_evt_t    core_evt_i = '0;
    logic                debug_request_in_i = 1'b0;
    dbgent_dbg_cmd_t     dbg_cmd_i;
    logic                debug_ack_o, sys_run_o, irq_mask_o, take_pf_abort_o;
    logic                abort_seen_o, irq_seen_o, pc_adv_valid_o;
    dbgent_cause_t       cause_o;
    dbgent_mode_t        mode_o;
    logic [2:0]          pc_adv_o;
    logic [PC_TOT_W-1:0] pc_total_o;
    int                  err_count = 0;
    int                  comparisons = 0;
    int                  ofs;
    always #20 sys_clk_i = ~sys_clk_i;
    dbgent_core u_dbgent_core (.sys_clk_i, .rst_b_i, .core_evt_i, .debug_request_in_i,
        .dbg_cmd_i, .debug_ack_o, .sys_run_o, .cause_o, .mode_o, .irq_mask_o, .take_pf_abort_o,
        .abort_seen_o, .irq_seen_o, .pc_adv_valid_o, .pc_adv_o, .pc_total_o);
    dbgent_dbg_model u_dbgent_dbg_model (.sys_clk_i, .debug_ack_i(debug_ack_o),
        .sys_run_i(sys_run_o), .cmd_o(dbg_cmd_i));
    task automatic check(input logic [7:0] seen, exp);
        comparisons++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize;
        $display("errors %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // one cycle of events, raised just after an edge
    task automatic fire(input logic [7:0] e);
        @(posedge sys_clk_i);
        #1 core_evt_i = e;
        @(posedge sys_clk_i);
        #1 core_evt_i = '0;
    endtask
    // random boundaries and harmless data aborts while running
    task automatic noise(input int n);
        repeat (n) begin
            @(posedge sys_clk_i);
            #1 core_evt_i = 8'($urandom) & 8'h88;
        end
        // idle cycle, so a request raised next meets no early boundary
        @(posedge sys_clk_i);
        #1 core_evt_i = '0;
    endtask
    function automatic int entry_adv(input dbgent_cause_t c);
        return (c == DBGENT_CAUSE_BKPT || c == DBGENT_CAUSE_WPT) ? 4 : 3;
    endfunction
    // entry, checks, random session, resume
    task automatic run_case(input logic [7:0] e, dbgent_cause_t c, dbgent_mode_t m,
                            input bit req, bit abt);
        int n;
        int s;
        noise(1 + $urandom % 4);
        debug_request_in_i = req;
        fire(e);
        debug_request_in_i = 1'b0;
        if (c == DBGENT_CAUSE_WPT_EXC) begin
            check(8'(debug_ack_o), 8'h0);
            fire(8'h01);
        end
        check(8'(cause_o), 8'(c));
        check(8'(pc_adv_o), 8'(entry_adv(c)));
        check(8'(irq_mask_o), 8'h1);
        if (m != DBGENT_MODE_USER) check(8'(mode_o), 8'(m));
        if (m == DBGENT_MODE_ABT) check(8'(abort_seen_o), 8'h1);
        if (m == DBGENT_MODE_IRQ) check(8'(irq_seen_o), 8'h1);
        n = 3 + $urandom % 4;
        s = $urandom % 3 + int'(abt);
        u_dbgent_dbg_model.session(entry_adv(c), n, s, abt, $urandom % 3, ofs);
        if (abt) check(8'(abort_seen_o), 8'h1);
        check(pc_total_o, 8'(ofs));
        u_dbgent_dbg_model.pulse(5'h01, 0);
        check(8'(debug_ack_o), 8'h0);
        check(8'(irq_mask_o), 8'h0);
    endtask
    initial begin
        void'($urandom(32'h0f2571e4));
        repeat (8) @(posedge sys_clk_i);
        #1 rst_b_i = 1'b1;
        repeat (3) @(posedge sys_clk_i);
        repeat (2) begin
            fire(8'hd0);
            check(8'(take_pf_abort_o), 8'h1);
            check(8'(debug_ack_o), 8'h0);
            run_case(8'hc0, DBGENT_CAUSE_BKPT, DBGENT_MODE_USER, 0, 0);
            run_case(8'ha0, DBGENT_CAUSE_WPT, DBGENT_MODE_USER, 0, 0);
            run_case(8'ha8, DBGENT_CAUSE_WPT_EXC, DBGENT_MODE_ABT, 0, 0);
            run_case(8'ha4, DBGENT_CAUSE_WPT_EXC, DBGENT_MODE_IRQ, 0, 0);
            run_case(8'ha2, DBGENT_CAUSE_WPT_EXC, DBGENT_MODE_FIQ, 0, 0);
            run_case(8'h80, DBGENT_CAUSE_REQ, DBGENT_MODE_USER, 1, 0);
            run_case(8'hc4, DBGENT_CAUSE_BKPT, DBGENT_MODE_IRQ, 0, 1);
            run_case(8'hc6, DBGENT_CAUSE_BKPT, DBGENT_MODE_FIQ, 0, 0);
        end
        summarize();
    end
    // watchdog well beyond the few hundred cycles the cases need
    initial begin
        #(20000 * 40);
        err_count++;
        summarize();
    end
endmodule

/* File: inc/dbgent_pkg.sv */
// shared types and constants for the debug entry controller
package dbgent_pkg;
    // program counter advances, in word addresses
    localparam logic [2:0] PC_ADV_BKPT    = 3'h4;
    localparam logic [2:0] PC_ADV_WPT     = 3'h4;
    localparam logic [2:0] PC_ADV_WPT_EXC = 3'h3;
    localparam logic [2:0] PC_ADV_REQ     = 3'h3;
    localparam logic [2:0] PC_ADV_SYS     = 3'h3;
    localparam logic [2:0] PC_ADV_STEP    = 3'h1;
    localparam int         PC_TOT_W       = 8;

    // reset values
    localparam logic [2:0]          PC_ADV_RST = 3'h0;
    localparam logic [PC_TOT_W-1:0] PC_TOT_RST = 8'h00;

    // processor mode the core sits in
    typedef enum logic [2:0] {
        DBGENT_MODE_USER,
        DBGENT_MODE_FIQ,
        DBGENT_MODE_IRQ,
        DBGENT_MODE_ABT
    } dbgent_mode_t;

    // reason for the latest debug entry
    typedef enum logic [2:0] {
        DBGENT_CAUSE_NONE,
        DBGENT_CAUSE_BKPT,
        DBGENT_CAUSE_WPT,
        DBGENT_CAUSE_WPT_EXC,
        DBGENT_CAUSE_REQ,
        DBGENT_CAUSE_SYS
    } dbgent_cause_t;

    // events from the core pipeline
    typedef struct packed {
        logic instr_done;
        logic bkpt;
        logic wpt;
        logic pf_abort;
        logic d_abort;
        logic irq;
        logic fiq;
        logic vec_fetched;
    } dbgent_core_evt_t;

    // commands from the scan side while halted
    typedef struct packed {
        logic step;
        logic sys_go;
        logic sys_done;
        logic sys_abort;
        logic resume;
    } dbgent_dbg_cmd_t;
endpackage
